//--- rfdrt_pkg.sv
// constants, types and decoders for the rf driver resistance/timing bank
package rfdrt_pkg;
   // ------------------------------------------------------------
   // register map (bit 8 selects the second register space)
   // ------------------------------------------------------------
   localparam int RFDRT_AW = 9;
   localparam logic [8:0] RFDRT_ADDR_TGT_RES = 9'h029;
   localparam logic [8:0] RFDRT_ADDR_TX_TIM = 9'h129;
   localparam logic [8:0] RFDRT_ADDR_STATUS = 9'h12B;
   localparam logic [7:0] RFDRT_TGT_RES_RST = 8'h70;
   localparam logic [7:0] RFDRT_TX_TIM_RST = 8'h7C;
   localparam logic [7:0] RFDRT_RD_NONE = 8'h00;

   // ------------------------------------------------------------
   // field positions and widths
   // ------------------------------------------------------------
   localparam int RFDRT_MOD_LSB = 4;
   localparam int RFDRT_UNMOD_LSB = 0;
   localparam int RFDRT_RAT_LSB = 4;
   localparam int RFDRT_MAN_BIT = 3;
   localparam int RFDRT_MAN_LSB = 0;
   localparam int RFDRT_RES_W = 4;
   localparam int RFDRT_TR_W = 3;
   localparam int RFDRT_ST_DONE_BIT = 3;
   localparam int RFDRT_ST_BUSY_BIT = 4;

   // ------------------------------------------------------------
   // codes
   // ------------------------------------------------------------
   localparam logic [3:0] RFDRT_RES_HIZ = 4'hF;
   localparam logic [2:0] RFDRT_TR_SLOW = 3'h0;
   localparam logic [2:0] RFDRT_TR_FAST = 3'h4;
   localparam logic [2:0] RFDRT_TR_STEP = 3'h1;
   localparam int RFDRT_NUM_STEPS = 5;
   localparam int RFDRT_ACQ_MAX_PERIODS = 10;

   typedef enum logic [1:0] {
      RFDRT_IDLE   = 2'b00,
      RFDRT_SETTLE = 2'b01,
      RFDRT_MEAS   = 2'b11,
      RFDRT_DONE   = 2'b10
   } rfdrt_state_t;

   // manual code to transient step: any code with top bit set is fast
   function automatic logic [2:0] rfdrt_manual_tr(input logic [2:0] code);
      rfdrt_manual_tr = code[2] ? RFDRT_TR_FAST : code;
   endfunction
endpackage

//--- rfdrt_acq.sv
// automatic driver transient acquisition, stepping slow towards fast
`timescale 1ns/1ps
module rfdrt_acq (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic acq_start,
   input wire logic rf_period_tick,
   input wire logic [3:0] meas_ratio,
   input wire logic [3:0] target_ratio,
   output logic [2:0] acq_step,
   output logic acq_busy,
   output logic acq_done
);
   import rfdrt_pkg::*;

   rfdrt_state_t state_q, state_d;
   logic [2:0] step_q, step_d;
   logic reached;

   // target met, or no faster step remains
   assign reached = (meas_ratio >= target_ratio) || (step_q == RFDRT_TR_FAST);

   // each step: one period to settle, one period to measure
   always_comb begin
      state_d = state_q;
      step_d = step_q;
      case (state_q)
         RFDRT_SETTLE: begin
            if (rf_period_tick) begin
               state_d = RFDRT_MEAS;
            end
         end
         RFDRT_MEAS: begin
            if (rf_period_tick) begin
               if (reached) begin // R6
                  state_d = RFDRT_DONE;
               end else begin
                  step_d = step_q + RFDRT_TR_STEP; // R6 R7
                  state_d = RFDRT_SETTLE;
               end
            end
         end
         default: state_d = state_q;
      endcase
      if (acq_start) begin
         state_d = RFDRT_SETTLE;
         step_d = RFDRT_TR_SLOW; // R6
      end
   end

   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= RFDRT_IDLE;
         step_q <= RFDRT_TR_SLOW;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
      end
   end

   assign acq_step = step_q;
   assign acq_busy = (state_q == RFDRT_SETTLE) || (state_q == RFDRT_MEAS);
   assign acq_done = (state_q == RFDRT_DONE);

   // helper: rf periods spent in one acquisition
   logic [4:0] per_cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         per_cnt_q <= 5'h00;
      end else if (acq_start) begin
         per_cnt_q <= 5'h00;
      end else if (acq_busy && rf_period_tick) begin
         per_cnt_q <= per_cnt_q + 5'h01;
      end
   end

   sequence s_meas_miss;
      state_q == RFDRT_MEAS && rf_period_tick && !reached && !acq_start;
   endsequence

   AST_START_SLOW: assert property (@(posedge clk) disable iff (!rst_n) // R6
      acq_start |=> step_q == RFDRT_TR_SLOW && state_q == RFDRT_SETTLE)
      else $error("acquisition did not start at slowest step");
   AST_STEP_FASTER: assert property (@(posedge clk) disable iff (!rst_n) // R6
      s_meas_miss |=> step_q == $past(step_q) + RFDRT_TR_STEP)
      else $error("acquisition did not step to faster transient");
   AST_STOP_AT_TARGET: assert property (@(posedge clk) // R6
      disable iff (!rst_n)
      state_q == RFDRT_MEAS && rf_period_tick && meas_ratio >= target_ratio
      && !acq_start |=> acq_done && $stable(step_q))
      else $error("acquisition did not stop at target");
   AST_FIVE_STEPS: assert property (@(posedge clk) disable iff (!rst_n) // R7
      step_q <= RFDRT_TR_FAST)
      else $error("acquisition stepped past fastest setting");
   AST_TEN_PERIODS: assert property (@(posedge clk) disable iff (!rst_n) // R7
      acq_busy |-> per_cnt_q < 5'(RFDRT_ACQ_MAX_PERIODS))
      else $error("acquisition exceeded ten rf periods");
endmodule

//--- rfdrt_bank.sv
// rf driver resistance and transient timing register bank
`timescale 1ns/1ps
// ------------------------------------------------------------
// Functional notes
// [R1] upper nibble: modulated-state driver resistance, reset 0111
// [R2] lower nibble: unmodulated-state driver resistance, reset 0
// [R3] host sets resistances before passive target mode
// [R4] codes 0-14 rising resistance, 15 high-z
// [R5] timing upper nibble: target non-overlap ratio, reset 0111
// [R6] start slowest, step faster until target met
// [R7] five steps, at most ten rf periods
// [R8] bit 3 picks manual (1) or acquired timing
// [R9] manual code 000..011 slow..medium fast, 1xx fast
// [R10] reset loads defaults, all bits read back
// ------------------------------------------------------------
module rfdrt_bank (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [rfdrt_pkg::RFDRT_AW-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic load_mod_active,
   input wire logic acq_start,
   input wire logic rf_period_tick,
   input wire logic [3:0] meas_ratio,
   output logic [3:0] rf_output_driver_res,
   output logic rf_output_driver_hiz,
   output logic [2:0] rf_output_driver_transient
);
   import rfdrt_pkg::*;

   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic [7:0] tgt_res_q;
   logic [7:0] tx_tim_q;
   logic [7:0] rdata_q, rdata_d;
   logic [3:0] drv_res_q;
   logic drv_hiz_q;
   logic [2:0] drv_tr_q;

   // address decode
   wire hit_pt = (reg_addr == RFDRT_ADDR_TGT_RES);
   wire hit_tim = (reg_addr == RFDRT_ADDR_TX_TIM);
   wire hit_st = (reg_addr == RFDRT_ADDR_STATUS);

   // field views
   wire [3:0] mod_drive_res = tgt_res_q[RFDRT_MOD_LSB +: RFDRT_RES_W];
   wire [3:0] unmodulated_state_drive_res =
      tgt_res_q[RFDRT_UNMOD_LSB +: RFDRT_RES_W];
   wire [3:0] target_ratio = tx_tim_q[RFDRT_RAT_LSB +: RFDRT_RES_W];
   wire man_sel = tx_tim_q[RFDRT_MAN_BIT];
   wire [2:0] man_code = tx_tim_q[RFDRT_MAN_LSB +: RFDRT_TR_W];

   // acquisition engine
   logic [2:0] acq_step;
   logic acq_busy;
   logic acq_done;
   rfdrt_acq u_acq (
      .clk(clk),
      .rst_n(rst_n),
      .acq_start(acq_start),
      .rf_period_tick(rf_period_tick),
      .meas_ratio(meas_ratio),
      .target_ratio(target_ratio), // R5
      .acq_step(acq_step),
      .acq_busy(acq_busy),
      .acq_done(acq_done)
   );

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // both registers load defaults at reset; full byte stored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tgt_res_q <= RFDRT_TGT_RES_RST; // R1 R2 R10
         tx_tim_q <= RFDRT_TX_TIM_RST; // R5 R8 R9 R10
      end else begin
         if (reg_wr && hit_pt) begin
            tgt_res_q <= reg_wdata; // R10
         end
         if (reg_wr && hit_tim) begin
            tx_tim_q <= reg_wdata; // R10
         end
      end
   end

   // ------------------------------------------------------------
   // read path, data one cycle after the strobe
   // ------------------------------------------------------------
   // status word: acquired step, done flag, busy flag, rest zero
   logic [7:0] status_word;
   always_comb begin
      status_word = RFDRT_RD_NONE;
      status_word[RFDRT_TR_W-1:0] = acq_step; // R6
      status_word[RFDRT_ST_DONE_BIT] = acq_done; // R7
      status_word[RFDRT_ST_BUSY_BIT] = acq_busy; // R7
   end

   // read select; unmapped places and idle cycles read zero
   always_comb begin
      rdata_d = RFDRT_RD_NONE;
      if (reg_rd) begin
         if (hit_pt) begin
            rdata_d = tgt_res_q; // R10
         end else if (hit_tim) begin
            rdata_d = tx_tim_q; // R10
         end else if (hit_st) begin
            rdata_d = status_word;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= RFDRT_RD_NONE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ------------------------------------------------------------
   // driver controls
   // ------------------------------------------------------------
   // resistance follows the load modulation state; the register
   // is expected settled before passive target mode is entered
   wire [3:0] sel_res = load_mod_active ? mod_drive_res // R1 R3
                                        : unmodulated_state_drive_res; // R2
   wire sel_hiz = (sel_res == RFDRT_RES_HIZ); // R4
   wire [2:0] sel_tr = man_sel ? rfdrt_manual_tr(man_code) // R8 R9
                               : acq_step; // R8

   // registered driver outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         drv_res_q <= RFDRT_RES_HIZ;
         drv_hiz_q <= 1'b1;
         drv_tr_q <= RFDRT_TR_SLOW;
      end else begin
         drv_res_q <= sel_res; // R4
         drv_hiz_q <= sel_hiz; // R4
         drv_tr_q <= sel_tr;
      end
   end

   assign rf_output_driver_res = drv_res_q;
   assign rf_output_driver_hiz = drv_hiz_q;
   assign rf_output_driver_transient = drv_tr_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_write_pt;
      reg_wr && hit_pt;
   endsequence

   sequence s_read_pt;
      ##1 reg_rd && hit_pt;
   endsequence

   AST_MOD_RES: assert property (@(posedge clk) disable iff (!rst_n) // R1
      load_mod_active |=> drv_res_q == $past(mod_drive_res))
      else $error("modulated resistance not applied");
   AST_UNMOD_RES: assert property (@(posedge clk) disable iff (!rst_n) // R2
      !load_mod_active |=> drv_res_q == $past(unmodulated_state_drive_res))
      else $error("unmodulated resistance not applied");
   AST_HIZ: assert property (@(posedge clk) disable iff (!rst_n) // R4
      drv_hiz_q == (drv_res_q == RFDRT_RES_HIZ))
      else $error("high-z flag disagrees with code");
   AST_MANUAL: assert property (@(posedge clk) disable iff (!rst_n) // R8
      man_sel && $stable(tx_tim_q) |=>
      drv_tr_q == rfdrt_manual_tr($past(man_code)))
      else $error("manual timing not applied");
   AST_MANUAL_FAST: assert property (@(posedge clk) disable iff (!rst_n) // R9
      man_sel && man_code[2] |=> drv_tr_q == RFDRT_TR_FAST)
      else $error("manual 1xx code not fast");
   AST_AUTO: assert property (@(posedge clk) disable iff (!rst_n) // R8
      !man_sel |=> drv_tr_q == $past(acq_step))
      else $error("acquired timing not applied");
   AST_READBACK: assert property (@(posedge clk) disable iff (!rst_n) // R10
      s_write_pt ##0 s_read_pt |=>
      reg_rdata == $past(reg_wdata, 2))
      else $error("register read back differs from write");
   AST_TIM_READ: assert property (@(posedge clk) disable iff (!rst_n) // R5
      reg_rd && hit_tim |=> reg_rdata == $past(tx_tim_q))
      else $error("timing register read wrong");

   // ------------------------------------------------------------
   // register bus checks
   // ------------------------------------------------------------
   sequence s_write_tim;
      reg_wr && hit_tim;
   endsequence

   sequence s_read_tim;
      ##1 reg_rd && hit_tim;
   endsequence

   sequence s_read_unmapped;
      reg_rd && !hit_pt && !hit_tim && !hit_st;
   endsequence

   // a strobed write lands in its register at the next edge
   AST_PT_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R10
      s_write_pt |=> tgt_res_q == $past(reg_wdata))
      else $error("resistance register write lost");
   AST_TIM_WRITE: assert property (@(posedge clk) disable iff (!rst_n) // R10
      s_write_tim |=> tx_tim_q == $past(reg_wdata))
      else $error("timing register write lost");

   // with no strobe on its address a register keeps its value
   AST_PT_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R10
      !(reg_wr && hit_pt) |=> $stable(tgt_res_q))
      else $error("resistance register changed without write");
   AST_TIM_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R10
      !(reg_wr && hit_tim) |=> $stable(tx_tim_q))
      else $error("timing register changed without write");

   // a write followed at once by a read returns the new value
   AST_TIM_RDBACK: assert property (@(posedge clk) disable iff (!rst_n) // R10
      s_write_tim ##0 s_read_tim |=>
      reg_rdata == $past(reg_wdata, 2))
      else $error("timing read back differs from write");

   // read data stand for one cycle only, then fall back to zero
   AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_n) // R10
      !reg_rd |=> reg_rdata == RFDRT_RD_NONE)
      else $error("read data not cleared after read cycle");

   // unmapped places read as zero
   AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n) // R10
      s_read_unmapped |=> reg_rdata == RFDRT_RD_NONE)
      else $error("unmapped read not zero");

   // resistance register read returns the stored byte
   AST_PT_READ: assert property (@(posedge clk) disable iff (!rst_n) // R10
      reg_rd && hit_pt |=> reg_rdata == $past(tgt_res_q))
      else $error("resistance register read wrong");

   // status shows the acquisition engine as it stood at the strobe
   AST_ST_READ: assert property (@(posedge clk) disable iff (!rst_n) // R6
      reg_rd && hit_st |=>
      reg_rdata[RFDRT_TR_W-1:0] == $past(acq_step)
      && reg_rdata[RFDRT_ST_DONE_BIT] == $past(acq_done)
      && reg_rdata[RFDRT_ST_BUSY_BIT] == $past(acq_busy))
      else $error("status read wrong");

   // ------------------------------------------------------------
   // driver output checks
   // ------------------------------------------------------------
   sequence s_mod_hiz;
      load_mod_active && mod_drive_res == RFDRT_RES_HIZ;
   endsequence

   sequence s_unmod_hiz;
      !load_mod_active && unmodulated_state_drive_res == RFDRT_RES_HIZ;
   endsequence

   // code 15 on the selected nibble turns the driver off
   AST_MOD_HIZ: assert property (@(posedge clk) disable iff (!rst_n) // R4
      s_mod_hiz |=> drv_hiz_q)
      else $error("modulated code 15 not high-z");
   AST_UNMOD_HIZ: assert property (@(posedge clk) disable iff (!rst_n) // R4
      s_unmod_hiz |=> drv_hiz_q)
      else $error("unmodulated code 15 not high-z");

   // codes 0 to 14 always leave the driver on
   AST_DRIVEN: assert property (@(posedge clk) disable iff (!rst_n) // R4
      sel_res != RFDRT_RES_HIZ |=> !drv_hiz_q)
      else $error("driver off for a resistance code");

   // manual codes 000 to 011 pass straight to the transient
   AST_MANUAL_LOW: assert property (@(posedge clk) disable iff (!rst_n) // R9
      man_sel && !man_code[2] |=> drv_tr_q == $past(man_code))
      else $error("manual low code not applied");

   // the applied transient never goes beyond the fastest step
   AST_TR_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // R9
      drv_tr_q <= RFDRT_TR_FAST)
      else $error("transient code out of range");
endmodule

//--- rfdrt_bank_tb.sv
// self-checking bench for the rf driver resistance and timing bank
`timescale 1ns/1ps
module rfdrt_bank_tb;
   import rfdrt_pkg::*;
   logic clk;
   logic rst_n;
   logic [RFDRT_AW-1:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic load_mod_active;
   logic acq_start;
   logic rf_period_tick;
   logic [3:0] meas_ratio;
   logic [3:0] res;
   logic hiz;
   logic [2:0] tr;
   int errors;
   int comparisons;

   rfdrt_bank uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .load_mod_active(load_mod_active),
      .acq_start(acq_start), .rf_period_tick(rf_period_tick),
      .meas_ratio(meas_ratio), .rf_output_driver_res(res),
      .rf_output_driver_hiz(hiz), .rf_output_driver_transient(tr));

   // ------------------------------------------------------------
   // clock, bus and compare helpers
   // ------------------------------------------------------------
   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // wait n edges, then step past them so outputs are settled
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data is sampled in the one cycle where it stands
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic tick(input logic [3:0] r);
      @(posedge clk);
      rf_period_tick <= 1'b1;
      meas_ratio <= r;
      @(posedge clk);
      rf_period_tick <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // defaults during and after reset
   task automatic t_reset;
      logic [7:0] d;
      idle(4);
      chk("res in reset", 8'h0F, {4'h0, res});
      chk("hiz in reset", 8'h01, {7'h0, hiz});
      chk("tr in reset", 8'h00, {5'h0, tr});
      chk("rdata in reset", 8'h00, reg_rdata);
      @(posedge clk);
      rst_n <= 1'b1;
      idle(2);
      chk("unmod res default", 8'h00, {4'h0, res});
      chk("transient default", 8'h04, {5'h0, tr});
      chk("hiz default", 8'h00, {7'h0, hiz});
      rd(RFDRT_ADDR_TGT_RES, d);
      chk("pt reset", 8'h70, d);
      rd(RFDRT_ADDR_TX_TIM, d);
      chk("timing reset", 8'h7C, d);
   endtask

   // every code in both nibbles, modulated and unmodulated state
   task automatic t_res;
      logic [7:0] d;
      for (int c = 0; c < 16; c++) begin
         wr(RFDRT_ADDR_TGT_RES, {4'(c), 4'(15 - c)});
         @(posedge clk);
         load_mod_active <= 1'b1;
         idle(2);
         chk("mod res", 8'(c), {4'h0, res});
         chk("mod hiz", {7'h0, c == 15}, {7'h0, hiz});
         @(posedge clk);
         load_mod_active <= 1'b0;
         idle(2);
         chk("unmod res", 8'(15 - c), {4'h0, res});
         chk("unmod hiz", {7'h0, c == 0}, {7'h0, hiz});
         rd(RFDRT_ADDR_TGT_RES, d);
         chk("pt readback", {4'(c), 4'(15 - c)}, d);
      end
   endtask

   // all eight manual codes with the manual source selected
   task automatic t_manual;
      logic [7:0] d;
      for (int m = 0; m < 8; m++) begin
         wr(RFDRT_ADDR_TX_TIM, {4'h7, 1'b1, 3'(m)});
         idle(2);
         chk("manual tr", (m >= 4) ? 8'h04 : 8'(m), {5'h0, tr});
         rd(RFDRT_ADDR_TX_TIM, d);
         chk("timing readback", {4'h7, 1'b1, 3'(m)}, d);
      end
   endtask

   // acquisition with one measured ratio per step, packed low first
   task automatic t_acq(input logic [3:0] tgt, input logic [19:0] rs);
      int stop;
      int n;
      logic [7:0] st;
      stop = 4;
      for (int k = 4; k >= 0; k--) if (rs[4*k +: 4] >= tgt) stop = k;
      wr(RFDRT_ADDR_TX_TIM, {tgt, 4'h0});
      @(posedge clk);
      acq_start <= 1'b1;
      @(posedge clk);
      acq_start <= 1'b0;
      n = 0;
      st = 8'h00;
      while (st[RFDRT_ST_DONE_BIT] !== 1'b1 && n < 10) begin
         tick(rs[4*(n/2) +: 4]);
         n++;
         rd(RFDRT_ADDR_STATUS, st);
      end
      chk("acq periods", 8'(2 * (stop + 1)), 8'(n));
      chk("acq step", 8'(stop), {5'h0, st[2:0]});
      chk("acq busy", 8'h00, {7'h0, st[RFDRT_ST_BUSY_BIT]});
      idle(2);
      chk("acquired tr", 8'(stop), {5'h0, tr});
   endtask

   // unmapped and read-only places, read data standing one cycle
   task automatic t_unmapped;
      logic [7:0] d;
      wr(RFDRT_ADDR_TGT_RES, 8'h3C);
      wr(9'h0AA, 8'h5A);
      rd(9'h0AA, d);
      chk("unmapped read", 8'h00, d);
      rd(RFDRT_ADDR_TGT_RES, d);
      idle(1);
      chk("rdata after read", 8'h00, reg_rdata);
      chk("pt unaltered", 8'h3C, d);
      wr(RFDRT_ADDR_STATUS, 8'hFF);
      rd(RFDRT_ADDR_STATUS, d);
      chk("status read only", 8'h08, d);
   endtask

   // write then read of the same place with no gap between strobes
   task automatic t_b2b(input logic [8:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("back to back read", v, reg_rdata);
   endtask

   // reset again in mid-run, after the registers were changed
   task automatic t_rereset;
      @(posedge clk);
      rst_n <= 1'b0;
      t_reset;
   endtask

   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #40000;
      errors++;
      end_of_test;
   end

   // main sequence
   initial begin
      errors = 0;
      comparisons = 0;
      rst_n = 1'b0;
      reg_addr = '0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      load_mod_active = 1'b0;
      acq_start = 1'b0;
      rf_period_tick = 1'b0;
      meas_ratio = 4'h0;
      repeat (3) @(posedge clk);
      t_reset;
      t_res;
      t_manual;
      t_acq(4'h3, {4'h6, 4'h5, 4'h3, 4'h2, 4'h1});
      t_acq(4'h7, 20'h00000);
      t_acq(4'h2, {4'h0, 4'h0, 4'h0, 4'h0, 4'h9});
      t_b2b(RFDRT_ADDR_TGT_RES, 8'h5F);
      t_b2b(RFDRT_ADDR_TX_TIM, 8'hA9);
      t_unmapped;
      t_rereset;
      end_of_test;
   end
endmodule
